// ### adcc_cfg.svh
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ****************************************************************
// Register byte offsets (low five address bits)
// ****************************************************************
`define ADCC_OFF_MODE      5'h00
`define ADCC_OFF_CHSEL     5'h04
`define ADCC_OFF_RESULT    5'h08
`define ADCC_OFF_RESULT_HI 5'h0C
`define ADCC_OFF_STATUS    5'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCC_MODE_START_BIT    7
`define ADCC_MODE_POWER_BIT    0
`define ADCC_STAT_END_BIT      0
`define ADCC_STAT_VALID_BIT    1
`define ADCC_STAT_SUSPECT_BIT  2
`define ADCC_RESULT_HI_W       8

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCC_MODE_RST      8'h00
`define ADCC_CHSEL_RST     8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ADCC_SETTLE_NS     1000
`define ADCC_CLK_PERIOD_NS 10
`define ADCC_SAMPLE_CYCLES 4

`endif

// ### adcc_pkg.sv
package adcc_pkg;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } adcc_state_t;

    typedef enum logic [2:0] {
        SAR_IDLE   = 3'b001,
        SAR_SAMPLE = 3'b010,
        SAR_CONV   = 3'b100
    } adcc_sar_state_t;

endpackage

// ### adcc_sar.sv
`include "adcc_cfg.svh"

module adcc_sar
    import adcc_pkg::*;
#(
    parameter int RES_W      = 10,
    parameter int SAMPLE_CYC = `ADCC_SAMPLE_CYCLES
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             comp_in,
    output logic                  busy,
    output logic                  done,
    output logic [RES_W-1:0]      result,
    output logic [RES_W-1:0]      dac_code,
    output logic                  sample_en
);

    localparam int BW  = $clog2(RES_W);
    localparam int SCW = $clog2(SAMPLE_CYC + 1);
    // The launch cycle, the sampling cycles and one cycle per bit pass before done rises.
    localparam int LAT = SAMPLE_CYC + RES_W + 1;

    if (SAMPLE_CYC < 1 || RES_W < 2) begin : g_bad
        $error("adcc_sar: unsupported parameters");
    end

    typedef struct packed {
        adcc_sar_state_t  state;
        logic [SCW-1:0]   cnt;
        logic [BW-1:0]    bit_idx;
        logic [RES_W-1:0] code;
        logic             done;
        logic [RES_W-1:0] result;
    } adcc_sar_regs_t;

    adcc_sar_regs_t s;
    adcc_sar_regs_t next_s;
    logic [BW-1:0]  next_idx;

    assign next_idx = s.bit_idx - 1'b1;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        unique case (s.state)
            SAR_IDLE: begin
                if (start && !abort) begin
                    next_s.state = SAR_SAMPLE;
                    next_s.cnt   = SCW'(SAMPLE_CYC - 1);
                end
            end
            SAR_SAMPLE: begin
                if (s.cnt == '0) begin
                    next_s.state   = SAR_CONV;
                    next_s.code    = {1'b1, {(RES_W-1){1'b0}}};
                    next_s.bit_idx = BW'(RES_W - 1);
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            SAR_CONV: begin
                // The comparator answers for the trial code on the DAC in the same cycle.
                if (!comp_in) begin
                    next_s.code[s.bit_idx] = 1'b0;
                end
                if (s.bit_idx == '0) begin
                    next_s.state  = SAR_IDLE;
                    next_s.done   = 1'b1;
                    next_s.result = next_s.code;
                end else begin
                    next_s.bit_idx        = next_idx;
                    next_s.code[next_idx] = 1'b1;
                end
            end
        endcase
        if (abort) begin
            next_s.state = SAR_IDLE;
            next_s.done  = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{state: SAR_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign busy      = (s.state != SAR_IDLE);
    assign done      = s.done;
    assign result    = s.result;
    assign dac_code  = s.code;
    assign sample_en = (s.state == SAR_SAMPLE);

    chk_sar_latency: assert property (@(posedge hclk) disable iff (!hresetn || abort)
        (start && !busy) |-> ##LAT done)
        else $error("conversion did not end after the sampling and bit cycles");

endmodule

// ### adcc_ctrl.sv
// Summary of operation
// - Mode or channel writes mark the result register as not valid unless a conversion completes in the same cycle.
// - Channel-select writes never clear the conversion-end flag.
// - A conversion in flight finishes on its latched old channel and reports.
// - First result flagged suspect if started unpowered or within 1 us of power.
// - Start bit 7, power bit 0; power-only keeps just the comparator on.
`include "adcc_cfg.svh"

module adcc_ctrl
    import adcc_pkg::*;
#(
    parameter int RES_W  = 10,
    parameter int NUM_CH = 4
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire logic                         comp_in,
    output logic [RES_W-1:0]                  dac_code,
    output logic                              sample_en,
    output logic [$clog2(NUM_CH)-1:0]         mux_sel,
    output logic                              comparator_power,
    output logic                              converter_active,
    output logic                              conv_end_irq
);

    localparam int CH_W       = $clog2(NUM_CH);
    localparam int SETTLE_CYC = (`ADCC_SETTLE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS;
    localparam int CNT_W      = $clog2(SETTLE_CYC + 1);
    localparam int HI_W       = `ADCC_RESULT_HI_W;

    if (RES_W < HI_W || RES_W > 16 || NUM_CH < 2 || NUM_CH > 256 || SETTLE_CYC < 1) begin : g_bad
        $error("adcc_ctrl: unsupported parameters");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        adcc_state_t      state;
        logic             mode_start;
        logic             mode_power;
        logic [CH_W-1:0]  chsel;
        logic [CH_W-1:0]  conv_ch;
        logic [RES_W-1:0] result;
        logic             flag;
        logic             result_valid;
        logic             suspect;
        logic             first_pending;
        logic             suspect_arm;
        logic [CNT_W-1:0] settle_cnt;
        logic             settle_done;
        logic             sar_start;
        logic             irq;
        logic             ap_valid;
        logic             ap_write;
        logic [4:0]       ap_addr;
        logic [31:0]      hrdata;
    } adcc_regs_t;

    adcc_regs_t       s;
    adcc_regs_t       next_s;
    logic [31:0]      rd_mux;
    logic             wr_mode;
    logic             wr_chsel;
    logic             wr_status;
    logic             sar_busy;
    logic             sar_done;
    logic [RES_W-1:0] sar_result;
    logic             sar_abort;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign wr_mode   = s.ap_valid && s.ap_write && (s.ap_addr == `ADCC_OFF_MODE);
    assign wr_chsel  = s.ap_valid && s.ap_write && (s.ap_addr == `ADCC_OFF_CHSEL);
    assign wr_status = s.ap_valid && s.ap_write && (s.ap_addr == `ADCC_OFF_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[4:0])
            `ADCC_OFF_MODE: begin
                rd_mux[`ADCC_MODE_START_BIT] = s.mode_start;
                rd_mux[`ADCC_MODE_POWER_BIT] = s.mode_power;
            end
            `ADCC_OFF_CHSEL:     rd_mux[CH_W-1:0] = s.chsel;
            `ADCC_OFF_RESULT:    rd_mux[RES_W-1:0] = s.result;
            `ADCC_OFF_RESULT_HI: rd_mux[HI_W-1:0] = s.result[RES_W-1 -: HI_W];
            `ADCC_OFF_STATUS: begin
                rd_mux[`ADCC_STAT_END_BIT]     = s.flag;
                rd_mux[`ADCC_STAT_VALID_BIT]   = s.result_valid;
                rd_mux[`ADCC_STAT_SUSPECT_BIT] = s.suspect;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_s           = s;
        next_s.sar_start = 1'b0;
        next_s.irq       = 1'b0;
        next_s.ap_valid  = hsel && hready && htrans[1];
        next_s.ap_write  = hwrite;
        next_s.ap_addr   = haddr[4:0];
        // Read data is captured in the address phase so that it leaves a flip-flop.
        if (next_s.ap_valid && !hwrite) begin
            next_s.hrdata = rd_mux;
        end

        if (wr_mode) begin
            if (hwdata[`ADCC_MODE_START_BIT] && !s.mode_start) begin
                next_s.first_pending = 1'b1;
                next_s.suspect_arm   = !hwdata[`ADCC_MODE_POWER_BIT] || !s.mode_power || !s.settle_done;
            end
            next_s.mode_start = hwdata[`ADCC_MODE_START_BIT];
            next_s.mode_power = hwdata[`ADCC_MODE_POWER_BIT];
        end
        if (wr_chsel) begin
            next_s.chsel = hwdata[CH_W-1:0];
        end
        if (wr_mode || wr_chsel) begin
            next_s.result_valid = 1'b0;
        end
        if (wr_status && hwdata[`ADCC_STAT_END_BIT]) begin
            next_s.flag = 1'b0;
        end

        if (!next_s.mode_power || !s.mode_power) begin
            next_s.settle_cnt  = '0;
            next_s.settle_done = 1'b0;
        end else if (!s.settle_done) begin
            if (s.settle_cnt == CNT_W'(SETTLE_CYC - 1)) begin
                next_s.settle_done = 1'b1;
            end else begin
                next_s.settle_cnt = s.settle_cnt + 1'b1;
            end
        end

        // waiting state keeps only the comparator
        if (next_s.mode_start) begin
            next_s.state = ST_RUN;
        end else if (next_s.mode_power) begin
            next_s.state = ST_WAIT;
        end else begin
            next_s.state = ST_OFF;
        end

        if (s.state == ST_RUN && next_s.state == ST_RUN && !sar_busy && !s.sar_start) begin
            next_s.sar_start = 1'b1;
            next_s.conv_ch   = s.chsel;
        end

        // completion loads result and flag
        // The hardware set sits after the software clear, so a finishing conversion is never lost.
        if (sar_done) begin
            next_s.result        = sar_result;
            next_s.flag          = 1'b1;
            next_s.irq           = 1'b1;
            next_s.result_valid  = 1'b1;
            next_s.suspect       = s.first_pending && s.suspect_arm;
            next_s.first_pending = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s            <= '{state: ST_OFF, default: '0};
            s.mode_start <= 1'(`ADCC_MODE_RST >> `ADCC_MODE_START_BIT);
            s.mode_power <= 1'(`ADCC_MODE_RST >> `ADCC_MODE_POWER_BIT);
            s.chsel      <= CH_W'(`ADCC_CHSEL_RST);
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Converter core
    // ****************************************************************
    // The core stops on the edge at which the start bit falls, so the waiting state
    // does not show a conversion still running for one cycle.
    assign sar_abort = (next_s.state != ST_RUN);

    adcc_sar #(
        .RES_W      (RES_W),
        .SAMPLE_CYC (`ADCC_SAMPLE_CYCLES)
    ) u_sar (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start     (s.sar_start),
        .abort     (sar_abort),
        .comp_in   (comp_in),
        .busy      (sar_busy),
        .done      (sar_done),
        .result    (sar_result),
        .dac_code  (dac_code),
        .sample_en (sample_en)
    );

    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = s.hrdata;
    assign mux_sel          = s.conv_ch;
    assign comparator_power = s.mode_power || s.mode_start;
    assign converter_active = (s.state == ST_RUN);
    assign conv_end_irq     = s.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_write_spoils: assert property (@(posedge hclk) disable iff (!hresetn)
        ((wr_mode || wr_chsel) && !sar_done) |=> !s.result_valid)
        else $error("result still valid after mode or channel write");

    chk_flag_chsel: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_chsel && s.flag && !wr_status) |=> s.flag)
        else $error("channel write cleared the end flag");

    chk_old_channel: assert property (@(posedge hclk) disable iff (!hresetn)
        (sar_busy && wr_chsel) |=> (mux_sel == $past(mux_sel)))
        else $error("conversion channel changed mid conversion");

    chk_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_status && hwdata[`ADCC_STAT_END_BIT] && !sar_done) |=> !s.flag)
        else $error("end flag not cleared by software");

    chk_settle_len: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(s.settle_done) |-> ($past(s.settle_cnt) == CNT_W'(SETTLE_CYC - 1)) && $past(s.mode_power))
        else $error("power settle time wrong");

    chk_suspect_unpowered: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_mode && !s.mode_start && hwdata[`ADCC_MODE_START_BIT] && !hwdata[`ADCC_MODE_POWER_BIT] && !sar_done)
        |=> (s.first_pending && s.suspect_arm))
        else $error("start without power not marked suspect");

    chk_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.state == ST_WAIT) |-> (comparator_power && !converter_active && !sar_busy && !s.sar_start))
        else $error("waiting state not comparator only");

    chk_done_loads: assert property (@(posedge hclk) disable iff (!hresetn)
        sar_done |=> (s.flag && conv_end_irq && s.result_valid && s.result == $past(sar_result)))
        else $error("completion did not load result, flag and interrupt");

    chk_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end_irq |-> ($past(sar_done) && s.flag))
        else $error("interrupt without a completed conversion");

    chk_irq_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        conv_end_irq |=> !conv_end_irq)
        else $error("end interrupt longer than one cycle");

    // Back-to-back conversion is the whole point of the running state.
    chk_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        (sar_done && s.mode_start && !wr_mode) |=> s.sar_start)
        else $error("running converter did not relaunch after completion");

    chk_chan_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        s.sar_start |-> (mux_sel == $past(s.chsel)))
        else $error("conversion did not latch the selected channel");

    chk_flag_held: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.flag && !wr_status) |=> s.flag)
        else $error("end flag dropped without a status write");

    chk_result_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        !sar_done |=> $stable(s.result))
        else $error("result changed without a completed conversion");

    chk_valid_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(s.result_valid) |-> $past(sar_done))
        else $error("result marked valid without a completion");

    chk_stopped_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !s.mode_start |-> (!sar_busy && !sample_en))
        else $error("converter busy while the start bit is clear");

    chk_suspect_early: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_mode && !s.mode_start && hwdata[`ADCC_MODE_START_BIT] && !s.settle_done) |=> s.suspect_arm)
        else $error("start before the power settled not marked suspect");

    chk_suspect_settled: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_mode && !s.mode_start && hwdata[`ADCC_MODE_START_BIT] && hwdata[`ADCC_MODE_POWER_BIT]
         && s.mode_power && s.settle_done) |=> !s.suspect_arm)
        else $error("start after the power settled marked suspect");

    chk_suspect_first: assert property (@(posedge hclk) disable iff (!hresetn)
        (sar_done && !s.first_pending) |=> !s.suspect)
        else $error("later result marked suspect");

endmodule

// ### adcc_analog_model.sv
module adcc_analog_model
    import adcc_pkg::*;
#(
    parameter int RES_W  = 10,
    parameter int NUM_CH = 4
) (
    input  wire logic                         hclk,
    input  wire logic [NUM_CH-1:0][RES_W-1:0] level,
    input  wire logic [$clog2(NUM_CH)-1:0]    mux_sel,
    input  wire logic [RES_W-1:0]             dac_code,
    input  wire logic                         comparator_power,
    output logic                              comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic noise = 1'b0;
    always @(posedge hclk) noise <= ~noise;
    // An unpowered comparator is not trusted, so it shows a moving pattern instead of a level.
    assign comp_in = comparator_power ? (level[mux_sel] >= dac_code) : noise;
endmodule

// ### tb.sv
`include "adcc_cfg.svh"

module tb
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} adcc_note_t;
    logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, dph;
    logic [31:0]      haddr, hwdata, hrdata;
    logic [1:0]       htrans, mux_sel, ch_a, ch_b;
    logic [2:0]       hsize;
    logic             comp_in, sample_en, comparator_power, converter_active, conv_end_irq;
    logic [9:0]       dac_code;
    logic [3:0][9:0]  level;
    int               error_cnt, n_tests, irq_cnt, mark;
    adcc_note_t       notes[$];

    adcc_ctrl #(.RES_W(10), .NUM_CH(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_in(comp_in), .dac_code(dac_code),
        .sample_en(sample_en), .mux_sel(mux_sel), .comparator_power(comparator_power),
        .converter_active(converter_active), .conv_end_irq(conv_end_irq));
    adcc_analog_model #(.RES_W(10), .NUM_CH(4)) analog (.hclk(hclk), .level(level), .mux_sel(mux_sel),
        .dac_code(dac_code), .comparator_power(comparator_power), .comp_in(comp_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************************************************************
    // Bus master and comparison
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic xfer(input logic [4:0] off, input logic wr, input logic [31:0] wdata);
        hsel   <= 1'b1;
        haddr  <= {27'h0, off};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    // xfer never overlaps phases, so a read straight after a write already sees the new value; the idle cycle only spaces transfers.
    task automatic wr(input logic [4:0] off, input logic [31:0] wdata);
        xfer(off, 1'b1, wdata);
        @(posedge hclk);
    endtask

    task automatic rd(input logic [4:0] off, input logic [31:0] exp, input logic [31:0] mask, input string name);
        adcc_note_t n;
        n.name = name;
        n.exp = exp;
        n.mask = mask;
        notes.push_back(n);
        xfer(off, 1'b0, 32'h0);
    endtask

    task automatic wait_irq();
        int start;
        start = irq_cnt;
        for (int k = 0; k < 400 && irq_cnt == start; k++) @(posedge hclk);
        check("irq_arrived", 32'(irq_cnt != start), 32'h1);
    endtask

    task automatic quiet(input int cycles, input string name);
        mark = irq_cnt;
        repeat (cycles) @(posedge hclk);
        check(name, 32'(irq_cnt - mark), 32'h0);
    endtask

    always @(posedge hclk) begin
        adcc_note_t n;
        if (dph) begin
            n = notes.pop_front();
            check(n.name, hrdata & n.mask, n.exp);
            check("hresp", {31'h0, hresp}, 32'h0);
            check("hready", {31'h0, hreadyout}, 32'h1);
        end
        dph <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
        if (conv_end_irq === 1'b1) irq_cnt++;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h36e0cf20));
        {hresetn, hsel, hwrite} = 3'h0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        for (int i = 0; i < 4; i++) level[i] = 10'($urandom_range(1023));
        ch_a = 2'($urandom_range(3));
        ch_b = ch_a + 2'h1;
        level[ch_b] = ~level[ch_a];
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`ADCC_OFF_MODE, 32'h0, 32'hFF, "mode_reset");
        rd(`ADCC_OFF_CHSEL, 32'h0, 32'h3, "chsel_reset");
        rd(`ADCC_OFF_STATUS, 32'h0, 32'h7, "status_reset");
        wr(5'h14, 32'hFFFFFFFF);
        rd(5'h14, 32'h0, 32'hFFFFFFFF, "unmapped");
        wr(`ADCC_OFF_MODE, 32'h01);
        quiet(40, "no_conv_waiting"); // waiting state is idle
        check("comp_power", {31'h0, comparator_power}, 32'h1); // comparator stays on
        check("active", {31'h0, converter_active}, 32'h0); // converter stopped
        check("sampling", {31'h0, sample_en}, 32'h0); // no sampling
        rd(`ADCC_OFF_MODE, 32'h01, 32'hFF, "mode_power"); // power bit position
        wr(`ADCC_OFF_CHSEL, {30'h0, ch_a});
        repeat (100) @(posedge hclk);
        wr(`ADCC_OFF_MODE, 32'h81);
        check("active", {31'h0, converter_active}, 32'h1); // start bit position
        wait_irq();
        rd(`ADCC_OFF_RESULT, {22'h0, level[ch_a]}, 32'h3FF, "result_a"); // result loaded
        rd(`ADCC_OFF_RESULT_HI, {24'h0, level[ch_a][9:2]}, 32'hFF, "result_hi_a"); // high byte
        rd(`ADCC_OFF_STATUS, 32'h3, 32'h7, "status_settled"); // settled start trusted
        wait_irq();
        rd(`ADCC_OFF_RESULT, {22'h0, level[ch_a]}, 32'h3FF, "result_repeat"); // repeated conversion
        wait_irq();
        repeat (4) @(posedge hclk);
        wr(`ADCC_OFF_CHSEL, {30'h0, ch_b});
        check("mux_old", {30'h0, mux_sel}, {30'h0, ch_a});
        rd(`ADCC_OFF_STATUS, 32'h1, 32'h3, "flag_kept_valid_gone"); // flag survives write
        wait_irq();
        rd(`ADCC_OFF_RESULT, {22'h0, level[ch_a]}, 32'h3FF, "old_channel"); // old input finishes
        wait_irq();
        rd(`ADCC_OFF_RESULT, {22'h0, level[ch_b]}, 32'h3FF, "new_channel"); // new input next
        check("mux_new", {30'h0, mux_sel}, {30'h0, ch_b});
        wr(`ADCC_OFF_MODE, 32'h01);
        rd(`ADCC_OFF_STATUS, 32'h0, 32'h2, "valid_after_mode"); // mode write spoils result
        wr(`ADCC_OFF_STATUS, 32'h1);
        rd(`ADCC_OFF_STATUS, 32'h0, 32'h1, "flag_cleared");
        quiet(40, "no_conv_stopped");
        for (int c = 0; c < 2; c++) begin
            wr(`ADCC_OFF_MODE, 32'h0);
            wr(`ADCC_OFF_STATUS, 32'h1);
            wr(`ADCC_OFF_MODE, (c == 0) ? 32'h80 : 32'h01);
            if (c == 1) wr(`ADCC_OFF_MODE, 32'h81);
            wait_irq();
            rd(`ADCC_OFF_STATUS, 32'h5, 32'h5, "first_suspect"); // early start flagged
            wait_irq();
            rd(`ADCC_OFF_STATUS, 32'h1, 32'h5, "second_trusted"); // only first result flagged
        end
        wr(`ADCC_OFF_MODE, 32'h0);
        tally_and_finish();
    end
endmodule
